// ---- axi_hs_pkg.sv ----
/*
 * shared constants and types for the point-to-point handshake port:
 * bus widths, response codes, burst encodings and state codes.
 * assumes both ends and the interface compile after this package.
 */
package axi_hs_pkg;
   localparam int ADDR_W = 32;
   localparam int DATA_W = 32;
   localparam int STRB_W = DATA_W / 8;
   localparam int ID_W = 4;
   localparam int LEN_W = 8;
   localparam int SIZE_W = 3;
   localparam int BURST_W = 2;
   localparam int CACHE_W = 4;
   localparam int PROT_W = 3;
   localparam int RESP_W = 2;
   localparam int MEM_DEPTH = 16;
   localparam int MEM_AW = 4;
   localparam int WORD_LSB = 2;
   localparam logic [RESP_W-1:0] RESP_OKAY = 2'h0;
   localparam logic [RESP_W-1:0] RESP_SLVERR = 2'h2;
   localparam logic [BURST_W-1:0] BURST_INCR = 2'h1;
   localparam logic [SIZE_W-1:0] SIZE_WORD = 3'h2;
   localparam logic [CACHE_W-1:0] CACHE_NONE = 4'h0;
   localparam logic [PROT_W-1:0] PROT_NONE = 3'h0;
   localparam logic [LEN_W-1:0] LEN_ONE = 8'h00;
   localparam logic [LEN_W-1:0] LEN_STEP = 8'h01;
   localparam logic [MEM_AW-1:0] WADDR_STEP = 4'h1;
   localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0;

   // slave write-side states
   typedef enum logic [2:0] {
      WS_ADDR = 3'b001,
      WS_DATA = 3'b010,
      WS_RESP = 3'b100
   } wr_state_e;

   // slave read-side states
   typedef enum logic [1:0] {
      RS_ADDR = 2'b01,
      RS_DATA = 2'b10
   } rd_state_e;

   // master states
   typedef enum logic [4:0] {
      MS_IDLE = 5'b00001,
      MS_WRITE = 5'b00010,
      MS_BRESP = 5'b00100,
      MS_READ = 5'b01000,
      MS_RDATA = 5'b10000
   } mst_state_e;
endpackage : axi_hs_pkg

// ---- axi_hs_if.sv ----
/*
 * the five-channel handshake port as an interface, one modport per end.
 * assumes one clock and one active-low reset supplied by the testbench.
 */
`timescale 1ns/100ps
interface axi_hs_if (
   input wire logic mclk, // interface clock
   input wire logic rst_n // async active-low reset
);
   logic [axi_hs_pkg::ID_W-1:0] awid;
   logic [axi_hs_pkg::ADDR_W-1:0] awaddr;
   logic [axi_hs_pkg::LEN_W-1:0] awlen;
   logic [axi_hs_pkg::SIZE_W-1:0] awsize;
   logic [axi_hs_pkg::BURST_W-1:0] awburst;
   logic awlock;
   logic [axi_hs_pkg::CACHE_W-1:0] awcache;
   logic [axi_hs_pkg::PROT_W-1:0] awprot;
   logic awvalid;
   logic awready;
   logic [axi_hs_pkg::DATA_W-1:0] wdata;
   logic [axi_hs_pkg::STRB_W-1:0] wstrb;
   logic wlast;
   logic wvalid;
   logic wready;
   logic [axi_hs_pkg::ID_W-1:0] bid;
   logic [axi_hs_pkg::RESP_W-1:0] bresp;
   logic bvalid;
   logic bready;
   logic [axi_hs_pkg::ID_W-1:0] arid;
   logic [axi_hs_pkg::ADDR_W-1:0] araddr;
   logic [axi_hs_pkg::LEN_W-1:0] arlen;
   logic [axi_hs_pkg::SIZE_W-1:0] arsize;
   logic [axi_hs_pkg::BURST_W-1:0] arburst;
   logic arlock;
   logic [axi_hs_pkg::CACHE_W-1:0] arcache;
   logic [axi_hs_pkg::PROT_W-1:0] arprot;
   logic arvalid;
   logic arready;
   logic [axi_hs_pkg::ID_W-1:0] rid;
   logic [axi_hs_pkg::DATA_W-1:0] rdata;
   logic [axi_hs_pkg::RESP_W-1:0] rresp;
   logic rlast;
   logic rvalid;
   logic rready;

   modport mst (
      input mclk, rst_n,
      output awid, awaddr, awlen, awsize, awburst, awlock, awcache, awprot, awvalid,
      input awready,
      output wdata, wstrb, wlast, wvalid,
      input wready,
      input bid, bresp, bvalid,
      output bready,
      output arid, araddr, arlen, arsize, arburst, arlock, arcache, arprot, arvalid,
      input arready,
      input rid, rdata, rresp, rlast, rvalid,
      output rready
   );

   modport slv (
      input mclk, rst_n,
      input awid, awaddr, awlen, awsize, awburst, awlock, awcache, awprot, awvalid,
      output awready,
      input wdata, wstrb, wlast, wvalid,
      output wready,
      output bid, bresp, bvalid,
      input bready,
      input arid, araddr, arlen, arsize, arburst, arlock, arcache, arprot, arvalid,
      output arready,
      output rid, rdata, rresp, rlast, rvalid,
      input rready
   );
endinterface : axi_hs_if

// ---- axi_hs_mem.sv ----
/*
 * small word memory with byte-lane write enables, registered read.
 * assumes the caller gives one write and one read port on mclk.
 */
`timescale 1ns/100ps
module axi_hs_mem (
   input wire logic mclk, // clock
   input wire logic clk_en, // freezes all state when low
   input wire logic wr_en, // write this cycle
   input wire logic [axi_hs_pkg::MEM_AW-1:0] wr_addr, // write word index
   input wire logic [axi_hs_pkg::DATA_W-1:0] wr_data, // write word
   input wire logic [axi_hs_pkg::STRB_W-1:0] wr_strb, // byte lanes to write
   input wire logic rd_en, // load read word
   input wire logic [axi_hs_pkg::MEM_AW-1:0] rd_addr, // read word index
   output logic [axi_hs_pkg::DATA_W-1:0] rd_data // registered read word
);
   logic [axi_hs_pkg::DATA_W-1:0] mem_r [axi_hs_pkg::MEM_DEPTH];

   // one lane writer per byte
   for (genvar b = 0; b < axi_hs_pkg::STRB_W; b++) begin : g_lane
      always_ff @(posedge mclk) begin
         if (clk_en && wr_en && wr_strb[b]) begin
            mem_r[wr_addr][b*8 +: 8] <= wr_data[b*8 +: 8];
         end
      end
   end

   // registered read port
   always_ff @(posedge mclk) begin
      if (clk_en && rd_en) begin
         rd_data <= mem_r[rd_addr];
      end
   end
endmodule : axi_hs_mem

// ---- axi_hs_slave.sv ----
/*
 * slave end of the handshake port: a small memory target with
 * independent write (address, data, response) and read sides.
 * assumes the master keeps its own side of the handshake; every
 * output here is a flip-flop so no input reaches an output directly.
 */
`timescale 1ns/100ps
module axi_hs_slave (
   axi_hs_if.slv bus, // handshake port, slave side
   input wire logic clk_en, // freezes all state when low
   input wire logic rd_stall, // holds read ready low while high
   output logic wr_busy, // write in progress
   output logic rd_busy // read in progress
);
   axi_hs_pkg::wr_state_e wst_r;
   axi_hs_pkg::rd_state_e rst_r;
   logic [axi_hs_pkg::MEM_AW-1:0] waddr_r;
   logic [axi_hs_pkg::MEM_AW-1:0] raddr_r;
   logic [axi_hs_pkg::LEN_W-1:0] rcnt_r;
   logic wr_err_r;
   logic rd_err_r;
   logic aw_fire;
   logic w_fire;
   logic b_fire;
   logic ar_fire;
   logic r_fire;
   logic [axi_hs_pkg::DATA_W-1:0] mem_q;
   logic mem_rd;
   logic [axi_hs_pkg::MEM_AW-1:0] mem_ra;

   assign aw_fire = bus.awvalid && bus.awready;
   assign w_fire = bus.wvalid && bus.wready;
   assign b_fire = bus.bvalid && bus.bready;
   assign ar_fire = bus.arvalid && bus.arready;
   assign r_fire = bus.rvalid && bus.rready;

   // read port: fetch on address or on next beat
   assign mem_rd = ar_fire || (r_fire && !bus.rlast);
   assign mem_ra = ar_fire ? bus.araddr[axi_hs_pkg::WORD_LSB +: axi_hs_pkg::MEM_AW]
                           : raddr_r;

   axi_hs_mem u_mem (
      .mclk(bus.mclk),
      .clk_en(clk_en),
      .wr_en(w_fire && !wr_err_r),
      .wr_addr(waddr_r),
      .wr_data(bus.wdata),
      .wr_strb(bus.wstrb),
      .rd_en(mem_rd),
      .rd_addr(mem_ra),
      .rd_data(mem_q)
   );

   // write side: address, data beats, then response
   // async assert, edge-only changes
   always_ff @(posedge bus.mclk or negedge bus.rst_n) begin
      if (!bus.rst_n) begin
         wst_r <= axi_hs_pkg::WS_ADDR;
         bus.awready <= 1'b0;
         bus.wready <= 1'b0;
         bus.bvalid <= 1'b0;
         bus.bid <= '0;
         bus.bresp <= axi_hs_pkg::RESP_OKAY;
         waddr_r <= '0;
         wr_err_r <= 1'b0;
      end else if (clk_en) begin
         case (wst_r)
            axi_hs_pkg::WS_ADDR: begin
               bus.awready <= 1'b1;
               if (aw_fire) begin
                  bus.awready <= 1'b0;
                  bus.wready <= 1'b1;
                  bus.bid <= bus.awid;
                  waddr_r <= bus.awaddr[axi_hs_pkg::WORD_LSB +: axi_hs_pkg::MEM_AW];
                  wr_err_r <= (bus.awsize != axi_hs_pkg::SIZE_WORD);
                  wst_r <= axi_hs_pkg::WS_DATA;
               end
            end
            axi_hs_pkg::WS_DATA: begin
               if (w_fire) begin
                  waddr_r <= waddr_r + axi_hs_pkg::WADDR_STEP;
                  if (bus.wlast) begin
                     // one response for the whole write
                     bus.wready <= 1'b0;
                     bus.bvalid <= 1'b1;
                     bus.bresp <= wr_err_r ? axi_hs_pkg::RESP_SLVERR
                                           : axi_hs_pkg::RESP_OKAY;
                     wst_r <= axi_hs_pkg::WS_RESP;
                  end
               end
            end
            axi_hs_pkg::WS_RESP: begin
               if (b_fire) begin
                  bus.bvalid <= 1'b0;
                  bus.awready <= 1'b1;
                  wst_r <= axi_hs_pkg::WS_ADDR;
               end
            end
            default: begin
               wst_r <= axi_hs_pkg::WS_ADDR;
               bus.awready <= 1'b0;
               bus.wready <= 1'b0;
               bus.bvalid <= 1'b0;
            end
         endcase
      end
   end

   // read side: address, then counted data beats
   always_ff @(posedge bus.mclk or negedge bus.rst_n) begin
      if (!bus.rst_n) begin
         rst_r <= axi_hs_pkg::RS_ADDR;
         bus.arready <= 1'b0;
         bus.rvalid <= 1'b0;
         bus.rlast <= 1'b0;
         bus.rid <= '0;
         bus.rresp <= axi_hs_pkg::RESP_OKAY;
         raddr_r <= '0;
         rcnt_r <= '0;
         rd_err_r <= 1'b0;
      end else if (clk_en) begin
         case (rst_r)
            axi_hs_pkg::RS_ADDR: begin
               // ready dropped while stalled, even before valid
               bus.arready <= !rd_stall;
               if (ar_fire) begin
                  // data only after an accepted address
                  bus.arready <= 1'b0;
                  bus.rvalid <= 1'b1;
                  bus.rid <= bus.arid;
                  bus.rlast <= (bus.arlen == axi_hs_pkg::LEN_ONE);
                  rd_err_r <= (bus.arsize != axi_hs_pkg::SIZE_WORD);
                  bus.rresp <= (bus.arsize != axi_hs_pkg::SIZE_WORD)
                               ? axi_hs_pkg::RESP_SLVERR : axi_hs_pkg::RESP_OKAY;
                  rcnt_r <= bus.arlen;
                  raddr_r <= mem_ra + axi_hs_pkg::WADDR_STEP;
                  rst_r <= axi_hs_pkg::RS_DATA;
               end
            end
            axi_hs_pkg::RS_DATA: begin
               if (r_fire) begin
                  if (bus.rlast) begin
                     bus.rvalid <= 1'b0;
                     bus.rlast <= 1'b0;
                     bus.arready <= !rd_stall;
                     rst_r <= axi_hs_pkg::RS_ADDR;
                  end else begin
                     rcnt_r <= rcnt_r - axi_hs_pkg::LEN_STEP;
                     bus.rlast <= (rcnt_r == axi_hs_pkg::LEN_STEP);
                     bus.rresp <= rd_err_r ? axi_hs_pkg::RESP_SLVERR
                                           : axi_hs_pkg::RESP_OKAY;
                     raddr_r <= raddr_r + axi_hs_pkg::WADDR_STEP;
                  end
               end
            end
            default: begin
               rst_r <= axi_hs_pkg::RS_ADDR;
               bus.arready <= 1'b0;
               bus.rvalid <= 1'b0;
            end
         endcase
      end
   end

   // data word from registered memory port
   assign bus.rdata = mem_q;

   // user-side status flags
   always_ff @(posedge bus.mclk or negedge bus.rst_n) begin
      if (!bus.rst_n) begin
         wr_busy <= 1'b0;
         rd_busy <= 1'b0;
      end else if (clk_en) begin
         wr_busy <= (wst_r != axi_hs_pkg::WS_ADDR) || aw_fire;
         rd_busy <= (rst_r != axi_hs_pkg::RS_ADDR) || ar_fire;
      end
   end
endmodule : axi_hs_slave

// ---- axi_hs_master.sv ----
/*
 * master end of the handshake port: runs one write or one read burst
 * per user command and returns status and read words.
 * assumes the user holds cmd fields while cmd_valid is high.
 */
`timescale 1ns/100ps
module axi_hs_master (
   axi_hs_if.mst bus, // handshake port, master side
   input wire logic clk_en, // freezes all state when low
   input wire logic cmd_valid, // start a burst, level
   input wire logic cmd_write, // 1 write, 0 read
   input wire logic [axi_hs_pkg::ADDR_W-1:0] cmd_addr, // first beat address
   input wire logic [axi_hs_pkg::LEN_W-1:0] cmd_len, // beats minus one
   input wire logic [axi_hs_pkg::ID_W-1:0] cmd_id, // transaction tag
   input wire logic [axi_hs_pkg::DATA_W-1:0] cmd_wdata, // base write word, plus beat no.
   input wire logic [axi_hs_pkg::STRB_W-1:0] cmd_wstrb, // byte lanes to write
   output logic cmd_ready, // idle, command taken on valid
   output logic done, // one-cycle burst end pulse
   output logic [axi_hs_pkg::RESP_W-1:0] resp, // last response seen
   output logic rd_word_valid, // one-cycle read word pulse
   output logic [axi_hs_pkg::DATA_W-1:0] rd_word // read word
);
   axi_hs_pkg::mst_state_e st_r;
   logic [axi_hs_pkg::LEN_W-1:0] left_r;
   logic [axi_hs_pkg::DATA_W-1:0] wbase_r;
   logic go;

   assign go = cmd_ready && cmd_valid;

   // valids low in reset, raised only from clocked state
   always_ff @(posedge bus.mclk or negedge bus.rst_n) begin
      if (!bus.rst_n) begin
         st_r <= axi_hs_pkg::MS_IDLE;
         cmd_ready <= 1'b0;
         bus.awvalid <= 1'b0;
         bus.wvalid <= 1'b0;
         bus.arvalid <= 1'b0;
         bus.bready <= 1'b0;
         bus.rready <= 1'b0;
         bus.wlast <= 1'b0;
         left_r <= '0;
         wbase_r <= '0;
         bus.wdata <= '0;
      end else if (clk_en) begin
         case (st_r)
            axi_hs_pkg::MS_IDLE: begin
               cmd_ready <= 1'b1;
               if (go) begin
                  cmd_ready <= 1'b0;
                  left_r <= cmd_len;
                  // valids raised without looking at ready
                  if (cmd_write) begin
                     bus.awvalid <= 1'b1;
                     bus.wvalid <= 1'b1;
                     bus.wdata <= cmd_wdata;
                     wbase_r <= cmd_wdata;
                     bus.wlast <= (cmd_len == axi_hs_pkg::LEN_ONE);
                     st_r <= axi_hs_pkg::MS_WRITE;
                  end else begin
                     bus.arvalid <= 1'b1;
                     bus.rready <= 1'b1;
                     st_r <= axi_hs_pkg::MS_READ;
                  end
               end
            end
            axi_hs_pkg::MS_WRITE: begin
               if (bus.awvalid && bus.awready) begin
                  bus.awvalid <= 1'b0;
               end
               // beats counted, wlast on final one
               if (bus.wvalid && bus.wready) begin
                  if (bus.wlast) begin
                     bus.wvalid <= 1'b0;
                     bus.wlast <= 1'b0;
                     st_r <= axi_hs_pkg::MS_BRESP;
                  end else begin
                     left_r <= left_r - axi_hs_pkg::LEN_STEP;
                     bus.wlast <= (left_r == axi_hs_pkg::LEN_STEP);
                     // beat index from the latched length, not the live command
                     bus.wdata <= wbase_r
                          + axi_hs_pkg::DATA_W'(bus.awlen - left_r + axi_hs_pkg::LEN_STEP);
                  end
               end
            end
            axi_hs_pkg::MS_BRESP: begin
               if (bus.bvalid && bus.bready) begin
                  bus.bready <= 1'b0;
                  bus.awvalid <= 1'b0;
                  st_r <= axi_hs_pkg::MS_IDLE;
               end else if (bus.bvalid) begin
                  bus.bready <= 1'b1;
               end
            end
            axi_hs_pkg::MS_READ: begin
               if (bus.arvalid && bus.arready) begin
                  bus.arvalid <= 1'b0;
                  st_r <= axi_hs_pkg::MS_RDATA;
               end
            end
            axi_hs_pkg::MS_RDATA: begin
               if (bus.rvalid && bus.rready && bus.rlast) begin
                  bus.rready <= 1'b0;
                  st_r <= axi_hs_pkg::MS_IDLE;
               end
            end
            default: begin
               st_r <= axi_hs_pkg::MS_IDLE;
               bus.awvalid <= 1'b0;
               bus.wvalid <= 1'b0;
               bus.arvalid <= 1'b0;
            end
         endcase
      end
   end

   // address groups latched at command, steady while valid
   always_ff @(posedge bus.mclk or negedge bus.rst_n) begin
      if (!bus.rst_n) begin
         bus.awid <= '0;
         bus.awaddr <= '0;
         bus.awlen <= '0;
         bus.arid <= '0;
         bus.araddr <= '0;
         bus.arlen <= '0;
         bus.wstrb <= '0;
      end else if (clk_en && go) begin
         bus.awid <= cmd_id;
         bus.awaddr <= cmd_addr;
         bus.awlen <= cmd_len;
         bus.arid <= cmd_id;
         bus.araddr <= cmd_addr;
         bus.arlen <= cmd_len;
         // one strobe bit per byte lane
         bus.wstrb <= cmd_wstrb;
      end
   end

   // fixed attributes, no region or user
   assign bus.awsize = axi_hs_pkg::SIZE_WORD;
   assign bus.awburst = axi_hs_pkg::BURST_INCR;
   assign bus.awlock = 1'b0;
   assign bus.awcache = axi_hs_pkg::CACHE_NONE;
   assign bus.awprot = axi_hs_pkg::PROT_NONE;
   assign bus.arsize = axi_hs_pkg::SIZE_WORD;
   assign bus.arburst = axi_hs_pkg::BURST_INCR;
   assign bus.arlock = 1'b0;
   assign bus.arcache = axi_hs_pkg::CACHE_NONE;
   assign bus.arprot = axi_hs_pkg::PROT_NONE;

   // user-side results
   always_ff @(posedge bus.mclk or negedge bus.rst_n) begin
      if (!bus.rst_n) begin
         done <= 1'b0;
         resp <= axi_hs_pkg::RESP_OKAY;
         rd_word_valid <= 1'b0;
         rd_word <= axi_hs_pkg::DATA_ZERO;
      end else if (clk_en) begin
         done <= (bus.bvalid && bus.bready) || (bus.rvalid && bus.rready && bus.rlast);
         rd_word_valid <= bus.rvalid && bus.rready;
         if (bus.rvalid && bus.rready) begin
            rd_word <= bus.rdata;
            resp <= bus.rresp;
         end else if (bus.bvalid && bus.bready) begin
            resp <= bus.bresp;
         end
      end
   end
endmodule : axi_hs_master

// ---- axi_hs_assertions.sv ----
/*
 * concurrent checks on the five handshake channels between the two ends.
 * assumes one clock, async active-low reset, instantiated beside the interface.
 */
`timescale 1ns/100ps
module axi_hs_assertions (
   input wire logic mclk, // interface clock
   input wire logic rst_n, // async active-low reset
   input wire logic [axi_hs_pkg::ADDR_W-1:0] awaddr, // write address
   input wire logic awvalid, // write address valid
   input wire logic awready, // write address ready
   input wire logic [axi_hs_pkg::DATA_W-1:0] wdata, // write data
   input wire logic [axi_hs_pkg::STRB_W-1:0] wstrb, // write lanes
   input wire logic wlast, // final write beat
   input wire logic wvalid, // write data valid
   input wire logic wready, // write data ready
   input wire logic [axi_hs_pkg::RESP_W-1:0] bresp, // write status
   input wire logic bvalid, // write status valid
   input wire logic bready, // write status ready
   input wire logic [axi_hs_pkg::ADDR_W-1:0] araddr, // read address
   input wire logic arvalid, // read address valid
   input wire logic arready, // read address ready
   input wire logic [axi_hs_pkg::DATA_W-1:0] rdata, // read data
   input wire logic rlast, // final read beat
   input wire logic rvalid, // read data valid
   input wire logic rready // read data ready
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   // waiting sources hold valid and payload
   aw_hold_a: assert property (awvalid && !awready |=> awvalid && $stable(awaddr))
      else $error("write address dropped or changed while waiting");
   w_hold_a: assert property (
      wvalid && !wready |=> wvalid && $stable({wdata, wstrb, wlast}))
      else $error("write data dropped or changed while waiting");
   b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write status dropped or changed while waiting");
   ar_hold_a: assert property (arvalid && !arready |=> arvalid && $stable(araddr))
      else $error("read address dropped or changed while waiting");
   r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable({rdata, rlast}))
      else $error("read data dropped or changed while waiting");
   // one write address per burst, taken on the handshake edge
   aw_once_a: assert property (awvalid && awready |=> !awvalid)
      else $error("write address repeated after its handshake");
   // write status only after the last write beat
   b_cause_a: assert property ($rose(bvalid) |-> $past(wvalid && wready && wlast))
      else $error("write status raised without last write beat");
   // read data follows its address or a previous beat
   r_cause_a: assert property (
      $rose(rvalid) |-> $past(arvalid && arready || rvalid && rready))
      else $error("read data raised without a request");
   w_end_a: assert property (wvalid && wready && wlast |=> !wvalid)
      else $error("write data continued after last beat");
   r_end_a: assert property (rvalid && rready && rlast |=> !rvalid)
      else $error("read data continued after last beat");
   // valids low while reset is held
   reset_low_a: assert property (
      disable iff (1'b0) !rst_n |-> !(arvalid | awvalid | wvalid | rvalid | bvalid))
      else $error("valid high during reset");
   release_edge_a: assert property ($rose(rst_n) |-> !(arvalid | awvalid | wvalid))
      else $error("master valid high at reset release edge");
endmodule : axi_hs_assertions

// ---- tb.sv ----
/*
 * self-checking bench: master and slave joined by the interface, random bursts
 * against a word model, plus reset abort. assumes the package compiles first.
 */
`timescale 1ns/100ps
module tb;
   logic mclk;
   logic rst_n;
   logic clk_en;
   logic rd_stall;
   logic cmd_valid;
   logic cmd_write;
   logic [axi_hs_pkg::ADDR_W-1:0] cmd_addr;
   logic [axi_hs_pkg::LEN_W-1:0] cmd_len;
   logic [axi_hs_pkg::ID_W-1:0] cmd_id;
   logic [axi_hs_pkg::DATA_W-1:0] cmd_wdata;
   logic [axi_hs_pkg::STRB_W-1:0] cmd_wstrb;
   logic cmd_ready;
   logic done;
   logic rd_word_valid;
   logic [axi_hs_pkg::RESP_W-1:0] resp;
   logic [axi_hs_pkg::DATA_W-1:0] rd_word;
   logic wr_busy;
   logic rd_busy;
   logic [31:0] model [16];
   int n_mismatch;
   int checks_done;

   axi_hs_if u_axi_hs_if (.mclk(mclk), .rst_n(rst_n));
   axi_hs_master u_axi_hs_master (.bus(u_axi_hs_if), .clk_en(clk_en), .cmd_valid(cmd_valid),
      .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_len(cmd_len), .cmd_id(cmd_id),
      .cmd_wdata(cmd_wdata), .cmd_wstrb(cmd_wstrb), .cmd_ready(cmd_ready), .done(done),
      .resp(resp), .rd_word_valid(rd_word_valid), .rd_word(rd_word));
   axi_hs_slave u_axi_hs_slave (.bus(u_axi_hs_if), .clk_en(clk_en), .rd_stall(rd_stall),
      .wr_busy(wr_busy), .rd_busy(rd_busy));
   axi_hs_assertions u_axi_hs_assertions (.mclk(mclk), .rst_n(rst_n),
      .awaddr(u_axi_hs_if.awaddr), .awvalid(u_axi_hs_if.awvalid), .awready(u_axi_hs_if.awready),
      .wdata(u_axi_hs_if.wdata), .wstrb(u_axi_hs_if.wstrb), .wlast(u_axi_hs_if.wlast),
      .wvalid(u_axi_hs_if.wvalid), .wready(u_axi_hs_if.wready), .bresp(u_axi_hs_if.bresp),
      .bvalid(u_axi_hs_if.bvalid), .bready(u_axi_hs_if.bready), .araddr(u_axi_hs_if.araddr),
      .arvalid(u_axi_hs_if.arvalid), .arready(u_axi_hs_if.arready), .rdata(u_axi_hs_if.rdata),
      .rlast(u_axi_hs_if.rlast), .rvalid(u_axi_hs_if.rvalid), .rready(u_axi_hs_if.rready));

   // free-running clock
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   // random read stalls drop ready ahead of valid
   always @(negedge mclk) begin
      rd_stall <= ($urandom % 4 == 0);
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic summarize();
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : summarize

   // byte-lane merge of a written word
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[8*i +: 8] = d[8*i +: 8];
         end
      end
      return r;
   endfunction : merge

   // one burst through the master, expectations from the word model
   task automatic burst(input logic wr, input logic [3:0] widx, input logic [7:0] len,
                        input logic [31:0] base, input logic [3:0] strb);
      int k;
      int n;
      logic [3:0] a;
      n = 0;
      while (cmd_ready !== 1'b1 && n < 100) begin
         @(negedge mclk);
         n++;
      end
      if (n >= 100) begin
         n_mismatch++;
      end
      cmd_write = wr;
      cmd_addr = {26'($urandom), widx, 2'b00};
      cmd_len = len;
      cmd_id = 4'($urandom);
      cmd_wdata = base;
      cmd_wstrb = strb;
      cmd_valid = 1'b1;
      @(negedge mclk);
      cmd_valid = 1'b0;
      for (k = 0; k <= len; k++) begin
         a = widx + k[3:0];
         if (wr) begin
            model[a] = merge(model[a], base + k, strb);
         end
      end
      k = 0;
      while (done !== 1'b1 && n < 300) begin
         @(negedge mclk);
         n++;
         if (rd_word_valid === 1'b1) begin
            a = widx + k[3:0];
            check("read word", rd_word, model[a]);
            k++;
         end
      end
      if (n >= 300) begin
         n_mismatch++;
         summarize();
      end else begin
         check("response", resp, axi_hs_pkg::RESP_OKAY);
         check("read beats", k, wr ? 0 : len + 1);
         check("busy flags", {30'h0, wr_busy, rd_busy}, wr ? 32'h2 : 32'h1);
      end
   endtask : burst

   initial begin
      n_mismatch = 0;
      checks_done = 0;
      void'($urandom(32'h069B));
      rst_n = 1'b0;
      clk_en = 1'b1;
      cmd_valid = 1'b0;
      cmd_write = 1'b0;
      cmd_addr = '0;
      cmd_len = '0;
      cmd_id = '0;
      cmd_wdata = '0;
      cmd_wstrb = '0;
      repeat (5) @(negedge mclk);
      check("ready in reset", cmd_ready, 1'b0);
      rst_n = 1'b1;
      // full fill starting mid-memory, wraps round
      burst(1'b1, 4'h5, 8'h0F, $urandom, 4'hF);
      for (int i = 0; i < 40; i++) begin
         burst(1'($urandom), 4'($urandom), 8'($urandom % 16), $urandom, 4'($urandom));
      end
      burst(1'b0, 4'hF, 8'h00, 32'h0, 4'h0);
      burst(1'b0, 4'h0, 8'h0F, 32'h0, 4'h0);
      // abort a long read by reset
      cmd_write = 1'b0;
      cmd_len = 8'h0F;
      cmd_valid = 1'b1;
      repeat (4) @(negedge mclk);
      cmd_valid = 1'b0;
      rst_n = 1'b0;
      @(negedge mclk);
      check("rvalid in reset", u_axi_hs_if.rvalid, 1'b0);
      check("bvalid in reset", u_axi_hs_if.bvalid, 1'b0);
      check("arvalid in reset", u_axi_hs_if.arvalid, 1'b0);
      repeat (2) @(negedge mclk);
      rst_n = 1'b1;
      burst(1'b1, 4'h3, 8'h00, 32'hA5A5_0F0F, 4'h5);
      burst(1'b0, 4'h3, 8'h00, 32'h0, 4'h0);
      summarize();
   end
endmodule : tb
